// ---- climit_pkg.sv ----
// Package with constants for the current-limit configuration and fault block
package climit_pkg;
	localparam int unsigned CLK_MHZ = 25;
	localparam int unsigned BLANK_NS = 224;
	localparam int unsigned BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned VIOL_DEFAULT = 5;
	localparam logic [7:0] STEP_MV = 8'h05;
	localparam logic [7:0] RANGE_LO_MV = 8'h19;
	localparam logic [7:0] RANGE_MID_MV = 8'h23;
	localparam logic [7:0] RANGE_HI_MV = 8'h32;
	localparam logic [4:0] RES_MID_BASE = 5'h06;
	localparam logic [4:0] RES_HI_BASE = 5'h0e;
	localparam logic [4:0] RES_LAST = 5'h18;
	localparam logic [1:0] STRAP_LOW = 2'h0;
	localparam logic [1:0] STRAP_OPEN = 2'h1;
	localparam logic [1:0] STRAP_HIGH = 2'h2;
	localparam logic [1:0] STRAP_RES = 2'h3;
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_LIMIT = 4'h1;
	localparam logic [3:0] ADDR_FAULT_CFG = 4'h2;
	localparam logic [3:0] ADDR_COMP = 4'h3;
	localparam logic [3:0] ADDR_PERIOD = 4'h4;
	localparam logic [3:0] ADDR_DUTY = 4'h5;
	localparam logic [3:0] ADDR_IRQ_STATUS = 4'h6;
	localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h7;
	localparam logic [3:0] ADDR_IRQ_CLEAR = 4'h8;
	localparam logic [3:0] ADDR_CFG_STATUS = 4'h9;
	localparam int unsigned IRQ_OC = 0;
	localparam int unsigned IRQ_UC = 1;
	localparam int unsigned IRQ_STRAP = 2;
	localparam logic [1:0] ACT_IGNORE = 2'h0;
	localparam logic [1:0] ACT_SHUTDOWN = 2'h1;
	localparam logic [1:0] ACT_LIMIT = 2'h2;
	localparam logic [7:0] PERIOD_RESET = 8'h3f;
	localparam logic [7:0] UC_LIMIT_RESET = 8'h00;
	localparam logic [7:0] FAULT_CFG_RESET = 8'h00;
endpackage

// ---- strap_if.sv ----
// Interface carrying strap decode request and result
`timescale 1ns/1ps
interface strap_if;
	logic [1:0] kind;
	logic [4:0] res_code;
	logic [7:0] limit_mv;
	logic [7:0] range_mv;
	modport decoder(input kind, input res_code, output limit_mv, output range_mv);
	modport user(output kind, output res_code, input limit_mv, input range_mv);
endinterface

// ---- strap_decode.sv ----
// Registered decoder from current-limit strap to threshold and range
`timescale 1ns/1ps
module strap_decode (
	input wire logic ref_clk,
	input wire logic rst,
	strap_if.decoder sif
);
	logic [7:0] next_limit;
	logic [7:0] next_range;
	logic [7:0] limit_q;
	logic [7:0] range_q;

	function automatic logic [7:0] steps(input logic [4:0] n);
		steps = 8'({3'h0, n}) * climit_pkg::STEP_MV;
	endfunction

	always_comb begin
		next_limit = climit_pkg::RANGE_HI_MV;
		next_range = climit_pkg::RANGE_HI_MV;
		case (sif.kind)
			climit_pkg::STRAP_LOW: begin
				next_limit = climit_pkg::RANGE_LO_MV;
				next_range = climit_pkg::RANGE_LO_MV;
			end
			climit_pkg::STRAP_OPEN: begin
				next_limit = climit_pkg::RANGE_MID_MV;
				next_range = climit_pkg::RANGE_MID_MV;
			end
			climit_pkg::STRAP_HIGH: begin
				next_limit = climit_pkg::RANGE_HI_MV;
				next_range = climit_pkg::RANGE_HI_MV;
			end
			default: begin
				// Codes past the top entry clamp to the last 50 mV setting
				if (sif.res_code < climit_pkg::RES_MID_BASE) begin
					next_limit = steps(sif.res_code);
					next_range = climit_pkg::RANGE_LO_MV;
				end else if (sif.res_code < climit_pkg::RES_HI_BASE) begin
					next_limit = steps(sif.res_code - climit_pkg::RES_MID_BASE);
					next_range = climit_pkg::RANGE_MID_MV;
				end else if (sif.res_code <= climit_pkg::RES_LAST) begin
					next_limit = steps(sif.res_code - climit_pkg::RES_HI_BASE);
					next_range = climit_pkg::RANGE_HI_MV;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			limit_q <= 8'h00;
			range_q <= 8'h00;
		end else begin
			limit_q <= next_limit;
			range_q <= next_range;
		end
	end

	assign sif.limit_mv = limit_q;
	assign sif.range_mv = range_q;
endmodule

// ---- current_limit_config_fault.sv ----
// Current-limit configuration, fault qualification and duty generation
`timescale 1ns/1ps
module current_limit_config_fault #(
	parameter int unsigned VIOL_ALLOWED = climit_pkg::VIOL_DEFAULT,
	parameter int unsigned BLANK_CYCLES = climit_pkg::BLANK_CYC
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [1:0] current_limit_strap_pin,
	input wire logic [4:0] limit_strap_resistor,
	input wire logic [4:0] compensation_strap_pin,
	input wire logic sample_valid,
	input wire logic [7:0] sense_mv,
	input wire logic sense_negative,
	input wire logic [7:0] error_value,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	output logic drive_high,
	output logic drive_low,
	output logic fault,
	output logic irq
);
	initial begin
		if (VIOL_ALLOWED < 1 || VIOL_ALLOWED > 200 || BLANK_CYCLES < 1 || BLANK_CYCLES > 200)
			$error("Unsupported parameter value");
	end

	typedef enum logic [2:0] {
		ST_SAMPLE = 3'b001,
		ST_DECODE = 3'b010,
		ST_RUN = 3'b100
	} phase_e;

	phase_e phase, next_phase;

	// Pin synchronisers: three stages, change accepted when stages two and three agree
	logic [1:0] lim_s1, lim_s2, lim_s3, lim_stable, next_lim_stable;
	logic [4:0] res_s1, res_s2, res_s3, res_stable, next_res_stable;
	logic [4:0] fc_s1, fc_s2, fc_s3, fc_stable, next_fc_stable;

	always_comb begin
		next_lim_stable = (lim_s2 == lim_s3) ? lim_s3 : lim_stable;
		next_res_stable = (res_s2 == res_s3) ? res_s3 : res_stable;
		next_fc_stable = (fc_s2 == fc_s3) ? fc_s3 : fc_stable;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			lim_s1 <= 2'h0;
			lim_s2 <= 2'h0;
			lim_s3 <= 2'h0;
			lim_stable <= 2'h0;
			res_s1 <= 5'h00;
			res_s2 <= 5'h00;
			res_s3 <= 5'h00;
			res_stable <= 5'h00;
			fc_s1 <= 5'h00;
			fc_s2 <= 5'h00;
			fc_s3 <= 5'h00;
			fc_stable <= 5'h00;
		end else begin
			lim_s1 <= current_limit_strap_pin;
			lim_s2 <= lim_s1;
			lim_s3 <= lim_s2;
			lim_stable <= next_lim_stable;
			res_s1 <= limit_strap_resistor;
			res_s2 <= res_s1;
			res_s3 <= res_s2;
			res_stable <= next_res_stable;
			fc_s1 <= compensation_strap_pin;
			fc_s2 <= fc_s1;
			fc_s3 <= fc_s2;
			fc_stable <= next_fc_stable;
		end
	end

	strap_if sif();
	assign sif.kind = lim_stable;
	assign sif.res_code = res_stable;

	strap_decode u_decode (
		.ref_clk(ref_clk),
		.rst(rst),
		.sif(sif)
	);

	// Configuration state
	logic [7:0] limit_mv, next_limit_mv;
	logic [7:0] range_mv, next_range_mv;
	logic [7:0] uc_limit_mv, next_uc_limit_mv;
	logic [4:0] comp_zero, next_comp_zero;
	logic [7:0] fault_cfg, next_fault_cfg;
	logic [7:0] period, next_period;
	logic [3:0] settle, next_settle;

	wire wr_limit = wr && addr == climit_pkg::ADDR_LIMIT;
	wire wr_comp = wr && addr == climit_pkg::ADDR_COMP;
	wire wr_cfg = wr && addr == climit_pkg::ADDR_FAULT_CFG;

	always_comb begin
		next_phase = phase;
		next_settle = settle;
		next_limit_mv = limit_mv;
		next_range_mv = range_mv;
		next_comp_zero = comp_zero;
		next_uc_limit_mv = (wr && addr == climit_pkg::ADDR_CTRL) ? wdata : uc_limit_mv;
		next_fault_cfg = wr_cfg ? wdata : fault_cfg;
		next_period = (wr && addr == climit_pkg::ADDR_PERIOD) ? wdata : period;
		case (phase)
			ST_SAMPLE: begin
				// Wait for synchronisers to fill before trusting strap levels
				next_settle = settle + 4'h1;
				if (settle == 4'h7)
					next_phase = ST_DECODE;
			end
			ST_DECODE: begin
				next_limit_mv = sif.limit_mv;
				next_range_mv = sif.range_mv;
				next_comp_zero = fc_stable;
				next_phase = ST_RUN;
			end
			ST_RUN: begin
				// Straps are not watched again; only software moves settings
			end
			default: next_phase = ST_SAMPLE;
		endcase
		if (wr_limit)
			next_limit_mv = wdata;
		if (wr_comp)
			next_comp_zero = wdata[4:0];
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			phase <= ST_SAMPLE;
			settle <= 4'h0;
			limit_mv <= 8'h00;
			range_mv <= 8'h00;
			comp_zero <= 5'h00;
			uc_limit_mv <= climit_pkg::UC_LIMIT_RESET;
			fault_cfg <= climit_pkg::FAULT_CFG_RESET;
			period <= climit_pkg::PERIOD_RESET;
		end else begin
			phase <= next_phase;
			settle <= next_settle;
			limit_mv <= next_limit_mv;
			range_mv <= next_range_mv;
			comp_zero <= next_comp_zero;
			uc_limit_mv <= next_uc_limit_mv;
			fault_cfg <= next_fault_cfg;
			period <= next_period;
		end
	end

	// PWM: period counter set by the period register, duty from integrated error
	logic [7:0] pwm_cnt, next_pwm_cnt;
	logic [15:0] integ, next_integ;
	logic [7:0] duty, next_duty;
	logic next_drive_high, next_drive_low;
	logic [7:0] blank_cnt, next_blank_cnt;
	logic [7:0] oc_cnt, next_oc_cnt;
	logic [7:0] uc_cnt, next_uc_cnt;
	logic oc_event, uc_event;
	logic next_fault;
	wire running = phase == ST_RUN;
	wire shut = fault && fault_cfg[1:0] == climit_pkg::ACT_SHUTDOWN;
	wire [7:0] viol_limit = (fault_cfg[7:2] == 6'h00) ? 8'(VIOL_ALLOWED) : {2'h0, fault_cfg[7:2]};
	wire [7:0] sense_clip = (sense_mv > range_mv) ? range_mv : sense_mv;

	always_comb begin
		next_pwm_cnt = (pwm_cnt >= period) ? 8'h00 : pwm_cnt + 8'h01;
		next_integ = integ + {{8{error_value[7]}}, error_value};
		next_duty = (pwm_cnt == 8'h00) ? integ[15:8] : duty;
		next_drive_high = running && !shut && pwm_cnt < duty;
		next_drive_low = running && !shut && pwm_cnt >= duty;
		// Blank counter restarts when the down-slope window opens
		next_blank_cnt = blank_cnt;
		if (!drive_low)
			next_blank_cnt = 8'h00;
		else if (blank_cnt < 8'(BLANK_CYCLES))
			next_blank_cnt = blank_cnt + 8'h01;
		oc_event = 1'b0;
		uc_event = 1'b0;
		next_oc_cnt = oc_cnt;
		next_uc_cnt = uc_cnt;
		if (running && sample_valid && drive_low && blank_cnt >= 8'(BLANK_CYCLES)) begin
			if (!sense_negative && sense_clip > limit_mv)
				next_oc_cnt = oc_cnt + 8'h01;
			else
				next_oc_cnt = 8'h00;
			if (sense_negative && sense_mv > uc_limit_mv && uc_limit_mv != 8'h00)
				next_uc_cnt = uc_cnt + 8'h01;
			else
				next_uc_cnt = 8'h00;
			oc_event = next_oc_cnt > viol_limit && oc_cnt <= viol_limit;
			uc_event = next_uc_cnt > viol_limit && uc_cnt <= viol_limit;
		end
		// Ignore action leaves fault low; the event still sets the interrupt status
		next_fault = fault;
		if ((oc_event || uc_event) && fault_cfg[1:0] != climit_pkg::ACT_IGNORE)
			next_fault = 1'b1;
		else if (wr_cfg)
			next_fault = 1'b0;
		if (fault && fault_cfg[1:0] == climit_pkg::ACT_LIMIT && pwm_cnt == 8'h00)
			next_duty = duty >> 1;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pwm_cnt <= 8'h00;
			integ <= 16'h0000;
			duty <= 8'h00;
			drive_high <= 1'b0;
			drive_low <= 1'b0;
			blank_cnt <= 8'h00;
			oc_cnt <= 8'h00;
			uc_cnt <= 8'h00;
			fault <= 1'b0;
		end else begin
			pwm_cnt <= next_pwm_cnt;
			integ <= next_integ;
			duty <= next_duty;
			drive_high <= next_drive_high;
			drive_low <= next_drive_low;
			blank_cnt <= next_blank_cnt;
			oc_cnt <= next_oc_cnt;
			uc_cnt <= next_uc_cnt;
			fault <= next_fault;
		end
	end

	// Interrupts and register read port
	logic [2:0] irq_status, next_irq_status;
	logic [2:0] irq_enable, next_irq_enable;
	logic next_irq;
	logic [7:0] next_rdata;

	always_comb begin
		next_irq_status = irq_status;
		if (wr && addr == climit_pkg::ADDR_IRQ_CLEAR)
			next_irq_status = irq_status & ~wdata[2:0];
		// Set beats a same-cycle clear
		next_irq_status[climit_pkg::IRQ_OC] = next_irq_status[climit_pkg::IRQ_OC] | oc_event;
		next_irq_status[climit_pkg::IRQ_UC] = next_irq_status[climit_pkg::IRQ_UC] | uc_event;
		next_irq_status[climit_pkg::IRQ_STRAP] = next_irq_status[climit_pkg::IRQ_STRAP] |
			(phase == ST_DECODE);
		next_irq_enable = (wr && addr == climit_pkg::ADDR_IRQ_ENABLE) ? wdata[2:0] : irq_enable;
		next_irq = |(next_irq_status & next_irq_enable);
		next_rdata = 8'h00;
		if (rd) begin
			case (addr)
				climit_pkg::ADDR_CTRL: next_rdata = uc_limit_mv;
				climit_pkg::ADDR_LIMIT: next_rdata = limit_mv;
				climit_pkg::ADDR_FAULT_CFG: next_rdata = fault_cfg;
				climit_pkg::ADDR_COMP: next_rdata = {3'h0, comp_zero};
				climit_pkg::ADDR_PERIOD: next_rdata = period;
				climit_pkg::ADDR_DUTY: next_rdata = duty;
				climit_pkg::ADDR_IRQ_STATUS: next_rdata = {5'h00, irq_status};
				climit_pkg::ADDR_IRQ_ENABLE: next_rdata = {5'h00, irq_enable};
				climit_pkg::ADDR_CFG_STATUS: next_rdata = {range_mv[5:0], fault, running};
				default: next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			irq_status <= 3'h0;
			irq_enable <= 3'h0;
			irq <= 1'b0;
			rdata <= 8'h00;
		end else begin
			irq_status <= next_irq_status;
			irq_enable <= next_irq_enable;
			irq <= next_irq;
			rdata <= next_rdata;
		end
	end
endmodule

// ---- climit_asserts.sv ----
// Port-level concurrent checks for the current-limit block
`timescale 1ns/1ps
module climit_asserts #(
	parameter int unsigned VIOL_ALLOWED = 5,
	parameter int unsigned BLANK_CYCLES = 6
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic sample_valid,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic drive_high,
	input wire logic drive_low,
	input wire logic fault,
	input wire logic irq
);
	logic [7:0] low_run;
	logic [7:0] hits;
	logic [7:0] age;
	// Hits is an upper bound on counted readings; blanking edge is judged leniently
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			low_run <= 8'h00;
			hits <= 8'h00;
			age <= 8'h00;
		end else begin
			low_run <= drive_low ? low_run + {7'h00, low_run != 8'hff} : 8'h00;
			if (sample_valid && drive_low && low_run >= 8'(BLANK_CYCLES - 1) && hits != 8'hff) begin
				hits <= hits + 8'h01;
			end
			age <= age + {7'h00, age != 8'hff};
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_rdata_stands: assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("read data outside its cycle");
	a_unmapped_zero: assert property (rd && addr >= 4'ha |=> rdata == 8'h00)
		else $error("unmapped read not zero");
	a_drive_exclusive: assert property (!(drive_high && drive_low))
		else $error("both drives on");
	a_fault_sticky: assert property (fault && !(wr && addr == climit_pkg::ADDR_FAULT_CFG)
		|=> fault)
		else $error("fault dropped without clear");
	a_fault_count: assert property ($rose(fault) |-> hits > 8'(VIOL_ALLOWED))
		else $error("fault before enough qualified readings");
	a_reset_quiet: assert property ($past(rst) |-> !drive_high && !drive_low && !fault && !irq
		&& rdata == 8'h00)
		else $error("outputs active after reset");
	a_limit_readback: assert property (age > 8'h20 && wr && addr == climit_pkg::ADDR_LIMIT
		##2 rd && addr == climit_pkg::ADDR_LIMIT |=> rdata == $past(wdata, 3))
		else $error("limit readback differs");
	a_comp_readback: assert property (age > 8'h20 && wr && addr == climit_pkg::ADDR_COMP
		##2 rd && addr == climit_pkg::ADDR_COMP |=> rdata[4:0] == $past(wdata[4:0], 3))
		else $error("compensation readback differs");
	a_irq_masked: assert property (wr && addr == climit_pkg::ADDR_IRQ_ENABLE && wdata == 8'h00
		##1 !wr [*2] |=> !irq)
		else $error("interrupt high while masked");
	cover property ($rose(fault));
	cover property ($rose(irq));
	cover property (rd && addr == climit_pkg::ADDR_LIMIT);
endmodule
bind current_limit_config_fault climit_asserts #(
	.VIOL_ALLOWED(VIOL_ALLOWED),
	.BLANK_CYCLES(BLANK_CYCLES)
) chk (
	.ref_clk(ref_clk),
	.rst(rst),
	.sample_valid(sample_valid),
	.addr(addr),
	.wdata(wdata),
	.wr(wr),
	.rd(rd),
	.rdata(rdata),
	.drive_high(drive_high),
	.drive_low(drive_low),
	.fault(fault),
	.irq(irq)
);

// ---- sense_net.sv ----
// Winding-resistance sense network and sampler feeding the block
`timescale 1ns/1ps
module sense_net (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic drive_low,
	input wire logic [7:0] level,
	output logic sample_valid,
	output logic [7:0] sense_mv,
	output logic sense_negative
);
	logic phase;
	always_ff @(posedge ref_clk) begin
		sense_negative <= 1'b0;
		if (rst) begin
			phase <= 1'b0;
			sample_valid <= 1'b0;
			sense_mv <= 8'h00;
		end else if (drive_low) begin
			phase <= ~phase;
			sample_valid <= phase;
			sense_mv <= level;
		end else begin
			// No reading off the down-slope, so the value keeps moving
			phase <= 1'b0;
			sample_valid <= 1'b0;
			sense_mv <= ~sense_mv;
		end
	end
endmodule

// ---- tb.sv ----
// Self-checking bench for the current-limit block
`timescale 1ns/1ps
module tb;
	logic ref_clk;
	logic rst;
	logic [1:0] current_limit_strap_pin;
	logic [4:0] limit_strap_resistor;
	logic [4:0] compensation_strap_pin;
	logic sample_valid;
	logic [7:0] sense_mv;
	logic sense_negative;
	logic [7:0] error_value;
	logic [3:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;
	logic drive_high;
	logic drive_low;
	logic fault;
	logic irq;
	logic [7:0] level;
	logic [7:0] v;
	logic [7:0] lim;
	logic [4:0] c;
	logic [4:0] corner [9] = '{5'h00, 5'h00, 5'h00, 5'h00, 5'h05, 5'h06, 5'h0d, 5'h0e, 5'h18};
	int fails;
	int num_checks;
	int i;
	int seed;
	int acc = 0;
	current_limit_config_fault #(.VIOL_ALLOWED(5), .BLANK_CYCLES(6)) uut (.ref_clk(ref_clk),
		.rst(rst), .current_limit_strap_pin(current_limit_strap_pin),
		.limit_strap_resistor(limit_strap_resistor), .compensation_strap_pin(compensation_strap_pin),
		.sample_valid(sample_valid), .sense_mv(sense_mv), .sense_negative(sense_negative),
		.error_value(error_value), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.drive_high(drive_high), .drive_low(drive_low), .fault(fault), .irq(irq));
	sense_net net (.ref_clk(ref_clk), .rst(rst), .drive_low(drive_low), .level(level),
		.sample_valid(sample_valid), .sense_mv(sense_mv), .sense_negative(sense_negative));
	function automatic logic [7:0] exp_range(input logic [1:0] k, input logic [4:0] r);
		if (k == 2'h0 || (k == 2'h3 && r < 5'h06)) return 8'h19;
		if (k == 2'h1 || (k == 2'h3 && r < 5'h0e)) return 8'h23;
		return 8'h32;
	endfunction
	function automatic logic [7:0] exp_limit(input logic [1:0] k, input logic [4:0] r);
		if (k != 2'h3) return exp_range(k, r);
		return 8'(r - ((r < 5'h06) ? 5'h00 : (r < 5'h0e) ? 5'h06 : 5'h0e)) * 8'h05;
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		if (fails == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		@(negedge ref_clk);
		d = rdata;
	endtask
	task automatic strap_case(input logic [1:0] k, input logic [4:0] r);
		logic [4:0] fc;
		fc = 5'($urandom_range(0, 31));
		@(posedge ref_clk);
		rst <= 1'b1;
		current_limit_strap_pin <= k;
		limit_strap_resistor <= r;
		compensation_strap_pin <= fc;
		tick(2);
		rst <= 1'b0;
		tick(30);
		rd_reg(climit_pkg::ADDR_LIMIT, v);
		check(v, exp_limit(k, r));
		rd_reg(climit_pkg::ADDR_CFG_STATUS, v);
		check({2'h0, v[7:2]}, exp_range(k, r) & 8'h3f);
		rd_reg(climit_pkg::ADDR_COMP, v);
		check({3'h0, v[4:0]}, {3'h0, fc});
		rd_reg(climit_pkg::ADDR_IRQ_STATUS, v);
		check(v & 8'h04, 8'h04);
		// Straps moved after decode must leave the held settings alone
		@(posedge ref_clk);
		current_limit_strap_pin <= ~k;
		limit_strap_resistor <= ~r;
		tick(20);
		rd_reg(climit_pkg::ADDR_LIMIT, v);
		check(v, exp_limit(k, r));
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	// Error is steered so the integrator sits near duty 16; a free walk could pin a drive phase off
	always @(posedge ref_clk) begin
		acc = rst ? 0 : acc + int'($signed(error_value));
		error_value <= 8'($urandom_range(0, 6)) - ((acc < 4096) ? 8'h00 : 8'h06);
	end
	initial begin
		seed = $urandom(32'hba55);
		{rst, wr, rd} = 3'h4;
		{addr, wdata, level} = '0;
		{current_limit_strap_pin, limit_strap_resistor, compensation_strap_pin} = '0;
		fails = 0;
		num_checks = 0;
		tick(20);
		rst <= 1'b0;
		tick(10);
		for (i = 0; i < 12; i++) begin
			c = (i < 9) ? corner[i] : 5'($urandom_range(0, 24));
			strap_case((i < 3) ? 2'(i) : climit_pkg::STRAP_RES, c);
		end
		strap_case(climit_pkg::STRAP_HIGH, 5'h00);
		lim = 8'($urandom_range(8, 40));
		wr_reg(climit_pkg::ADDR_LIMIT, lim);
		rd_reg(climit_pkg::ADDR_LIMIT, v);
		check(v, lim);
		c = 5'($urandom_range(0, 31));
		wr_reg(climit_pkg::ADDR_COMP, {3'h0, c});
		rd_reg(climit_pkg::ADDR_COMP, v);
		check({3'h0, v[4:0]}, {3'h0, c});
		wr_reg(4'hb, 8'h5a);
		rd_reg(4'ha, v);
		check(v, 8'h00);
		rd_reg(4'hb, v);
		check(v, 8'h00);
		level <= lim - 8'h01;
		wr_reg(climit_pkg::ADDR_FAULT_CFG, {6'h00, climit_pkg::ACT_SHUTDOWN});
		wr_reg(climit_pkg::ADDR_IRQ_ENABLE, 8'h01);
		tick(400);
		check({7'h0, fault}, 8'h00);
		level <= lim + 8'($urandom_range(1, 10));
		i = 0;
		while (fault !== 1'b1 && i < 4000) begin
			@(negedge ref_clk);
			i++;
		end
		if (i == 4000)
			fails++;
		tick(2);
		@(negedge ref_clk);
		check({4'h0, drive_high, drive_low, irq, fault}, 8'h03);
		level <= lim - 8'h01;
		tick(20);
		wr_reg(climit_pkg::ADDR_IRQ_CLEAR, 8'h01);
		rd_reg(climit_pkg::ADDR_IRQ_STATUS, v);
		check(v & 8'h01, 8'h00);
		wr_reg(climit_pkg::ADDR_IRQ_ENABLE, 8'h00);
		tick(4);
		check({7'h0, irq}, 8'h00);
		wr_reg(climit_pkg::ADDR_FAULT_CFG, {6'h00, climit_pkg::ACT_SHUTDOWN});
		tick(2);
		check({7'h0, fault}, 8'h00);
		finish_test();
	end
endmodule
